//--- pkg/drive_monitor_consts.svh
// Address map, field positions and timing constants of the drive monitor
`ifndef DRIVE_MONITOR_CONSTS_SVH
`define DRIVE_MONITOR_CONSTS_SVH

// ----------------------------------------------------------------------------
// Host addresses
// ----------------------------------------------------------------------------
`define MON_BASE            16'h7000
`define MON_LAST            16'h7044
`define COMM_REF_ADDR       16'h1000
`define ADDR_PULSE_KHZ      16'h7012
`define ADDR_LINE_SPEED     16'h7018
`define ADDR_PULSE_HZ       16'h701b
`define ADDR_COMM_SETTING   16'h701c
`define ADDR_RESOLVER       16'h7024
`define ADDR_QUAD_COUNT     16'h7026
`define ADDR_FUNC_DISP_LOW  16'h702b
`define ADDR_FUNC_DISP_HIGH 16'h702c
`define ADDR_INDEX_COUNT    16'h703a
`define ADDR_SET_PCT        16'h703b
`define ADDR_RUN_PCT        16'h703c
`define ADDR_RUN_STATE      16'h703d
`define ADDR_FAULT_CODE     16'h703e
`define ADDR_FOLLOWERS      16'h7040
`define ADDR_FIELDBUS       16'h7044
`define ADDR_MOTOR_SELECT   16'h7049

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FB_RUN_BIT          0
`define FB_REV_BIT          1
`define FB_FAULT_BIT        2
`define FB_AT_TARGET_BIT    3
`define FB_CODE_LSB         8
`define RS_DIR_LSB          0
`define RS_RAMP_LSB         2
`define RS_UNDERVOLT_BIT    4

// ----------------------------------------------------------------------------
// Scaling and timing
// ----------------------------------------------------------------------------
`define PCT_FULL_SCALE      10000
`define SECONDS_PER_MINUTE  60
`define HZ_PER_CENTI_KHZ    10
`define CLK_KHZ             100000
`define GATE_TIME_MS        1000
`define GATE_CYCLES         (`GATE_TIME_MS * `CLK_KHZ)
`define RESET_VALUE         16'h0000

`endif

//--- pkg/drive_monitor_pkg.sv
// Types shared by the drive monitor design
`default_nettype none
package drive_monitor_pkg;

  // Direction field of the running-state word
  typedef enum logic [1:0] {DIR_STOP, DIR_FORWARD, DIR_REVERSE} run_dir_t;

  // Ramp field of the running-state word
  typedef enum logic [1:0] {RAMP_CONSTANT, RAMP_ACCEL, RAMP_DECEL} ramp_t;

  // Whole state of the monitor in one record
  typedef struct packed {
    logic [1:0] a_sync;
    logic [1:0] b_sync;
    logic [1:0] z_sync;
    logic [1:0] p_sync;
    logic a_prev;
    logic b_prev;
    logic z_prev;
    logic p_prev;
    logic last_forward;
    logic [15:0] quad_count;
    logic [15:0] index_count;
    logic [31:0] gate_count;
    logic [16:0] pulse_count;
    logic [15:0] pulse_hz;
    logic [15:0] comm_setting;
    logic rd_valid;
    logic [15:0] rd_data;
    logic [39:0] disp_low;
    logic [23:0] disp_high;
  } mon_state_t;

endpackage
`default_nettype wire

//--- hw/drive_monitor_status.sv
// Drive monitoring block: encoder counters, status words, scaled readouts
// ----------------------------------------------------------------------------
// Summary of operation
// [RULE_01] Every A and B edge counts, four counts per encoder pulse.
// [RULE_02] Forward rotation increments the position count, reverse decrements it.
// [RULE_03] Counting up past 65535 wraps to 0.
// [RULE_04] Counting down below 0 wraps to 65535.
// [RULE_05] Index counter steps by one per revolution, signed by direction, 16 bits.
// [RULE_06] Resolver angle is reported as a 12-bit value.
// [RULE_07] Fieldbus word: run, reverse, fault bits; bits 4-7 zero; fault code 8-15.
// [RULE_08] Fieldbus bit 3 is set when output frequency reached target.
// [RULE_09] Run word: bits 1:0 stop/fwd/rev, bits 3:2 constant/accel/decel.
// [RULE_10] Run word bit 4 flags DC bus undervoltage.
// [RULE_11] Functions 1-40 map to five 8-segment digits, rightmost first; lit is active.
// [RULE_12] Functions 41-59 map to three digits, right to left, same format.
// [RULE_13] Set and running frequency are signed percent of maximum frequency.
// [RULE_14] Comm setting readout mirrors the last host write to the reference address.
// [RULE_15] Fast pulse frequency is reported in whole hertz.
// [RULE_16] Line speed is pulses per minute divided by pulses per meter.
// [RULE_17] Active fault code is reported as 0 to 99.
// [RULE_18] Motor select reads 0 for first set, 1 for second.
// [RULE_19] Follower count on the point-to-point link is 0 to 63.
// [RULE_20] Monitor values are host readable in the monitoring address range; motor select is read at 16'h7049, above MON_LAST.
// [RULE_21] Readouts are read only; writes ignored, reads have no side effect.
// [RULE_22] Each read returns one atomic snapshot taken in a single cycle.
// ----------------------------------------------------------------------------
`include "drive_monitor_consts.svh"
`default_nettype none

module drive_monitor_status
  import drive_monitor_pkg::*;
#(
  parameter int unsigned GATE_CYCLES = `GATE_CYCLES
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Encoder and pulse pins
  input wire logic i_quad_a,
  input wire logic i_quad_b,
  input wire logic i_quad_z,
  input wire logic i_fast_pulse,
  // Drive status from the control core
  input wire logic [11:0] i_resolver_angle,
  input wire logic i_run,
  input wire logic i_reverse,
  input wire logic i_accel,
  input wire logic i_decel,
  input wire logic i_at_target,
  input wire logic i_undervoltage,
  input wire logic [7:0] i_fault_code,
  input wire logic i_motor2,
  input wire logic [5:0] i_follower_count,
  input wire logic [58:0] i_func_valid,
  input wire logic [15:0] i_set_freq,
  input wire logic [15:0] i_run_freq,
  input wire logic [15:0] i_max_freq,
  input wire logic [15:0] i_pulses_per_meter,
  // Host access
  input wire logic i_rd_req,
  input wire logic i_wr_req,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic o_rd_valid,
  output logic [15:0] o_rd_data,
  // Panel digits
  output logic [39:0] o_func_display_low,
  output logic [23:0] o_func_display_high
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------

  // Signed frequency as percent of maximum, in 0.01 % units, clamped
  function automatic logic [15:0] pct_of_max(input logic [15:0] freq, input logic [15:0] fmax);
    logic signed [31:0] num;
    logic signed [31:0] quo;
    num = 32'($signed(freq)) * 32'sd10000;
    quo = 32'sd0;
    if (fmax != 16'h0000)
    begin
      quo = num / $signed({16'h0000, fmax});
    end
    if (quo > 32'(`PCT_FULL_SCALE))
    begin
      quo = 32'(`PCT_FULL_SCALE);
    end
    if (quo < -32'(`PCT_FULL_SCALE))
    begin
      quo = -32'(`PCT_FULL_SCALE);
    end
    return quo[15:0];
  endfunction

  // Saturate a wide unsigned value to one register word
  function automatic logic [15:0] sat16(input logic [31:0] value);
    return (value > 32'h0000_ffff) ? 16'hffff : value[15:0];
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  mon_state_t state;
  mon_state_t next_state;

  logic a_now;
  logic b_now;
  logic quad_step;
  logic quad_up;
  logic [31:0] per_minute;
  logic [31:0] line_speed;
  run_dir_t run_dir;
  ramp_t ramp;
  logic [15:0] run_word;
  logic [15:0] fieldbus_word;
  logic [15:0] read_mux;

  // Second synchroniser stage feeds the decoder
  assign a_now = state.a_sync[1];
  assign b_now = state.b_sync[1];

  // One bit changed means a legal step; both changed is a glitch and is dropped
  assign quad_step = (a_now ^ state.a_prev) ^ (b_now ^ state.b_prev); // RULE_01
  assign quad_up = a_now ^ state.b_prev; // RULE_02

  // Line speed from the one-second frequency measurement
  assign per_minute = 32'(state.pulse_hz) * 32'(`SECONDS_PER_MINUTE);
  assign line_speed = (i_pulses_per_meter == 16'h0000) ? 32'h0000_0000
                      : per_minute / {16'h0000, i_pulses_per_meter}; // RULE_16

  // --------------------------------------------------------------------------
  // Status words
  // --------------------------------------------------------------------------
  always_comb
  begin
    run_dir = DIR_STOP;
    if (i_run)
    begin
      run_dir = i_reverse ? DIR_REVERSE : DIR_FORWARD; // RULE_09
    end
    ramp = RAMP_CONSTANT;
    if (i_accel)
    begin
      ramp = RAMP_ACCEL; // RULE_09
    end
    else if (i_decel)
    begin
      ramp = RAMP_DECEL;
    end
    run_word = 16'h0000;
    run_word[`RS_DIR_LSB +: 2] = run_dir; // RULE_09
    run_word[`RS_RAMP_LSB +: 2] = ramp;
    run_word[`RS_UNDERVOLT_BIT] = i_undervoltage; // RULE_10
    fieldbus_word = 16'h0000; // RULE_07
    fieldbus_word[`FB_RUN_BIT] = i_run;
    fieldbus_word[`FB_REV_BIT] = i_reverse;
    fieldbus_word[`FB_FAULT_BIT] = (i_fault_code != 8'h00);
    fieldbus_word[`FB_AT_TARGET_BIT] = i_at_target; // RULE_08
    fieldbus_word[`FB_CODE_LSB +: 8] = i_fault_code; // RULE_17
  end

  // --------------------------------------------------------------------------
  // Read decode, all values sampled in the same cycle
  // --------------------------------------------------------------------------
  always_comb
  begin
    read_mux = `RESET_VALUE;
    case (i_addr) // RULE_20
      `ADDR_PULSE_KHZ: read_mux = state.pulse_hz / 16'(`HZ_PER_CENTI_KHZ);
      `ADDR_LINE_SPEED: read_mux = sat16(line_speed); // RULE_16
      `ADDR_PULSE_HZ: read_mux = state.pulse_hz; // RULE_15
      `ADDR_COMM_SETTING: read_mux = state.comm_setting; // RULE_14
      `ADDR_RESOLVER: read_mux = {4'h0, i_resolver_angle}; // RULE_06
      `ADDR_QUAD_COUNT: read_mux = state.quad_count;
      `ADDR_FUNC_DISP_LOW: read_mux = state.disp_low[15:0];
      `ADDR_FUNC_DISP_HIGH: read_mux = state.disp_high[15:0];
      `ADDR_INDEX_COUNT: read_mux = state.index_count;
      `ADDR_SET_PCT: read_mux = pct_of_max(i_set_freq, i_max_freq); // RULE_13
      `ADDR_RUN_PCT: read_mux = pct_of_max(i_run_freq, i_max_freq); // RULE_13
      `ADDR_RUN_STATE: read_mux = run_word;
      `ADDR_FAULT_CODE: read_mux = {8'h00, i_fault_code}; // RULE_17
      `ADDR_FOLLOWERS: read_mux = {10'h000, i_follower_count}; // RULE_19
      `ADDR_FIELDBUS: read_mux = fieldbus_word;
      `ADDR_MOTOR_SELECT: read_mux = {15'h0000, i_motor2}; // RULE_18
      default: read_mux = `RESET_VALUE;
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    // Pins pass two flops before any logic looks at them
    next_state.a_sync = {state.a_sync[0], i_quad_a};
    next_state.b_sync = {state.b_sync[0], i_quad_b};
    next_state.z_sync = {state.z_sync[0], i_quad_z};
    next_state.p_sync = {state.p_sync[0], i_fast_pulse};
    next_state.a_prev = a_now;
    next_state.b_prev = b_now;
    next_state.z_prev = state.z_sync[1];
    next_state.p_prev = state.p_sync[1];

    // Edge counter; natural 16-bit wrap in both directions
    if (quad_step)
    begin
      next_state.last_forward = quad_up;
      if (quad_up)
      begin
        next_state.quad_count = state.quad_count + 16'h0001; // RULE_03
      end
      else
      begin
        next_state.quad_count = state.quad_count - 16'h0001; // RULE_04
      end
    end

    // Index pulse counts one revolution in the last seen direction
    if (state.z_sync[1] && !state.z_prev)
    begin
      if (state.last_forward)
      begin
        next_state.index_count = state.index_count + 16'h0001; // RULE_05
      end
      else
      begin
        next_state.index_count = state.index_count - 16'h0001; // RULE_05
      end
    end

    // One-second gate; an edge on the last gate cycle lands in the result
    if (state.p_sync[1] && !state.p_prev && (state.pulse_count != 17'h1ffff))
    begin
      next_state.pulse_count = state.pulse_count + 17'h00001;
    end
    if (state.gate_count >= 32'(GATE_CYCLES - 1))
    begin
      next_state.gate_count = 32'h0000_0000;
      next_state.pulse_hz = sat16(32'(next_state.pulse_count)); // RULE_15
      next_state.pulse_count = 17'h00000;
    end
    else
    begin
      next_state.gate_count = state.gate_count + 32'h0000_0001;
    end

    // Only the reference address is writable; monitor addresses ignore writes
    if (i_wr_req && (i_addr == `COMM_REF_ADDR))
    begin
      next_state.comm_setting = i_wdata; // RULE_14
    end

    // Panel digits: digit n holds functions 8n+1 to 8n+8, digit 0 rightmost
    next_state.disp_low = i_func_valid[39:0]; // RULE_11
    next_state.disp_high = {5'h00, i_func_valid[58:40]}; // RULE_12

    // Reads only copy a snapshot, never touch counters
    next_state.rd_valid = i_rd_req; // RULE_21
    if (i_rd_req)
    begin
      next_state.rd_data = read_mux; // RULE_22
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs straight from flops
  assign o_rd_valid = state.rd_valid;
  assign o_rd_data = state.rd_data;
  assign o_func_display_low = state.disp_low;
  assign o_func_display_high = state.disp_high;

endmodule // drive_monitor_status

`default_nettype wire

//--- verification/drive_monitor_props.sv
// Port checker for the drive monitor
`include "drive_monitor_consts.svh"
`default_nettype none
module drive_monitor_props (
  // Clock, reset, host
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_rd_req,
  input wire logic [15:0] i_addr,
  // Status inputs
  input wire logic [11:0] i_resolver_angle,
  input wire logic i_run,
  input wire logic i_reverse,
  input wire logic i_accel,
  input wire logic i_decel,
  input wire logic i_at_target,
  input wire logic i_undervoltage,
  input wire logic [7:0] i_fault_code,
  input wire logic [58:0] i_func_valid,
  // Outputs
  input wire logic o_rd_valid,
  input wire logic [15:0] o_rd_data,
  input wire logic [39:0] o_func_display_low,
  input wire logic [23:0] o_func_display_high
);
  logic [1:0] dir_exp;
  logic [1:0] ramp_exp;
  logic [15:0] run_exp;
  logic [15:0] fb_exp;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // ----
  // Expected words, accel wins over decel
  // ----
  assign dir_exp = !i_run ? 2'h0 : (i_reverse ? 2'h2 : 2'h1);
  assign ramp_exp = i_accel ? 2'h1 : (i_decel ? 2'h2 : 2'h0);
  assign run_exp = {11'h0, i_undervoltage, ramp_exp, dir_exp};
  assign fb_exp = {i_fault_code, 4'h0, i_at_target, |i_fault_code, i_reverse, i_run};
  // Host answers, one cycle after the read edge
  a_read_answer: assert property (i_rd_req |=> o_rd_valid)
    else $error("read got no answer");
  a_no_spurious: assert property (!i_rd_req |=> !o_rd_valid)
    else $error("answer without read");
  a_data_holds: assert property (!i_rd_req |=> $stable(o_rd_data))
    else $error("read data moved without read");
  a_fault_read: assert property (i_rd_req && i_addr == `ADDR_FAULT_CODE
    |=> o_rd_data == {8'h00, $past(i_fault_code)}) else $error("fault code wrong");
  a_fieldbus_word: assert property (i_rd_req && i_addr == `ADDR_FIELDBUS
    |=> o_rd_data == $past(fb_exp)) else $error("fieldbus word wrong");
  a_run_word: assert property (i_rd_req && i_addr == `ADDR_RUN_STATE
    |=> o_rd_data == $past(run_exp)) else $error("run word wrong");
  a_resolver_read: assert property (i_rd_req && i_addr == `ADDR_RESOLVER
    |=> o_rd_data == {4'h0, $past(i_resolver_angle)}) else $error("angle wrong");
  // Panel digits follow the flags one cycle late
  a_display_low: assert property ($past(i_rstn)
    |-> o_func_display_low == $past(i_func_valid[39:0])) else $error("low digits wrong");
  a_display_high: assert property ($past(i_rstn)
    |-> o_func_display_high == {5'h0, $past(i_func_valid[58:40])})
    else $error("high digits wrong");
endmodule // drive_monitor_props
bind drive_monitor_status drive_monitor_props u_props (.i_clk, .i_rstn, .i_rd_req,
  .i_addr, .i_resolver_angle, .i_run, .i_reverse, .i_accel, .i_decel, .i_at_target,
  .i_undervoltage, .i_fault_code, .i_func_valid, .o_rd_valid, .o_rd_data,
  .o_func_display_low, .o_func_display_high);
`default_nettype wire

//--- verification/encoder_pulse_model.sv
// Behavioural encoder and fast pulse source facing the monitor pins
`default_nettype none
module encoder_pulse_model (
  // Clock and control
  input wire logic i_clk,
  input wire logic i_pulse_on,
  // Pins toward the monitor
  output logic o_quad_a,
  output logic o_quad_b,
  output logic o_quad_z,
  output logic o_fast_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] phase = 2'h0;
  logic [1:0] pdiv = 2'h0;
  // Gray phases, A leads B when going forward
  assign o_quad_a = phase[0] ^ phase[1];
  assign o_quad_b = phase[1];
  assign o_fast_pulse = pdiv[1];
  initial o_quad_z = 1'b0;
  // Period of four clocks, so a gate of 100 sees 25 edges
  always @(posedge i_clk) pdiv <= i_pulse_on ? pdiv + 2'h1 : 2'h0;
  // One step, then wait out the synchroniser
  task automatic step(input bit fwd);
    @(posedge i_clk);
    phase <= fwd ? phase + 2'h1 : phase - 2'h1;
    repeat (4) @(posedge i_clk);
  endtask
  // One index mark, long enough to pass the synchroniser
  task automatic index_mark();
    @(posedge i_clk);
    o_quad_z <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_quad_z <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
endmodule // encoder_pulse_model
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the drive monitor
`include "drive_monitor_consts.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rstn = 1'b0, pon = 1'b1, qa, qb, qz, fp, rv;
  logic run = 1'b0, rev = 1'b0, acc = 1'b0, dec = 1'b0, at = 1'b0, uv = 1'b0, m2 = 1'b0;
  logic rd_req = 1'b0, wr_req = 1'b0;
  logic [15:0] addr = 16'h0, wdata = 16'h0, setf = 16'h0, runf = 16'h0, rdat;
  logic [15:0] maxf = 16'h03e8, ppm = 16'h0003;
  logic [11:0] angle = 12'h0;
  logic [7:0] fault = 8'h0;
  logic [5:0] fol = 6'h0;
  logic [58:0] fv = 59'h0;
  logic [39:0] dlo;
  logic [23:0] dhi;
  int bad_count = 0;
  int comparisons = 0;
  encoder_pulse_model u_far (.i_clk(clk), .i_pulse_on(pon), .o_quad_a(qa),
    .o_quad_b(qb), .o_quad_z(qz), .o_fast_pulse(fp));
  drive_monitor_status #(.GATE_CYCLES(100)) u_dut (.i_clk(clk), .i_rstn(rstn),
    .i_quad_a(qa), .i_quad_b(qb), .i_quad_z(qz), .i_fast_pulse(fp),
    .i_resolver_angle(angle), .i_run(run), .i_reverse(rev), .i_accel(acc),
    .i_decel(dec), .i_at_target(at), .i_undervoltage(uv), .i_fault_code(fault),
    .i_motor2(m2), .i_follower_count(fol), .i_func_valid(fv), .i_set_freq(setf),
    .i_run_freq(runf), .i_max_freq(maxf), .i_pulses_per_meter(ppm), .i_rd_req(rd_req),
    .i_wr_req(wr_req), .i_addr(addr), .i_wdata(wdata), .o_rd_valid(rv),
    .o_rd_data(rdat), .o_func_display_low(dlo), .o_func_display_high(dhi));
  // ----
  // Access tasks
  // ----
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Read held until the edge that takes it, answer seen one cycle on
  task automatic rd_chk(input logic [15:0] ad, input logic [15:0] exp);
    @(posedge clk);
    rd_req <= 1'b1;
    addr <= ad;
    @(posedge clk);
    rd_req <= 1'b0;
    #1;
    chk({39'h0, rv}, 40'h1);
    chk({24'h0, rdat}, {24'h0, exp});
  endtask
  task automatic wr(input logic [15:0] ad, input logic [15:0] d);
    @(posedge clk);
    wr_req <= 1'b1;
    addr <= ad;
    wdata <= d;
    @(posedge clk);
    wr_req <= 1'b0;
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    forever #5 clk = ~clk;
  end
  // Watchdog, several times the expected run length
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
  // ----
  // Test sequence
  // ----
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(`ADDR_QUAD_COUNT, 16'h0000);
    wr(`ADDR_QUAD_COUNT, 16'h1234);
    rd_chk(`ADDR_QUAD_COUNT, 16'h0000);
    rd_chk(16'h7045, 16'h0000);
    done("reset");
    repeat (4) u_far.step(1'b1);
    rd_chk(`ADDR_QUAD_COUNT, 16'h0004);
    u_far.step(1'b0);
    rd_chk(`ADDR_QUAD_COUNT, 16'h0003);
    repeat (4) u_far.step(1'b0);
    rd_chk(`ADDR_QUAD_COUNT, 16'hffff);
    rd_chk(`ADDR_QUAD_COUNT, 16'hffff);
    u_far.step(1'b1);
    rd_chk(`ADDR_QUAD_COUNT, 16'h0000);
    u_far.index_mark();
    rd_chk(`ADDR_INDEX_COUNT, 16'h0001);
    u_far.step(1'b0);
    u_far.index_mark();
    u_far.index_mark();
    rd_chk(`ADDR_INDEX_COUNT, 16'hffff);
    done("encoder");
    // Every status combination, fault code and angle swept alongside
    for (int i = 0; i < 64; i++)
    begin
      @(posedge clk);
      {uv, at, dec, acc, rev, run} <= i[5:0];
      fault <= {2'h0, i[5:0]};
      m2 <= i[0];
      fol <= i[5:0];
      angle <= {i[5:0], i[5:0]};
      rd_chk(`ADDR_RUN_STATE, {11'h0, i[5], i[2] ? 2'h1 : {i[3], 1'b0},
        i[0] ? {i[1], !i[1]} : 2'h0});
      rd_chk(`ADDR_FIELDBUS, {2'h0, i[5:0], 4'h0, i[4], |i[5:0], i[1:0]});
      rd_chk(`ADDR_FAULT_CODE, {10'h0, i[5:0]});
      rd_chk(`ADDR_MOTOR_SELECT, {15'h0, i[0]});
      rd_chk(`ADDR_FOLLOWERS, {10'h0, i[5:0]});
      rd_chk(`ADDR_RESOLVER, {4'h0, i[5:0], i[5:0]});
    end
    done("status");
    @(posedge clk);
    setf <= 16'h01f4;
    runf <= 16'hff06;
    rd_chk(`ADDR_SET_PCT, 16'h1388);
    rd_chk(`ADDR_RUN_PCT, 16'hf63c);
    @(posedge clk);
    setf <= 16'h07d0;
    rd_chk(`ADDR_SET_PCT, 16'h2710);
    // A four times larger maximum quarters the share; zero maximum must read as zero
    @(posedge clk);
    maxf <= 16'h0fa0;
    rd_chk(`ADDR_SET_PCT, 16'h1388);
    @(posedge clk);
    maxf <= 16'h0000;
    rd_chk(`ADDR_RUN_PCT, 16'h0000);
    wr(`COMM_REF_ADDR, 16'hd8f0);
    rd_chk(`ADDR_COMM_SETTING, 16'hd8f0);
    wr(`ADDR_COMM_SETTING, 16'h1234);
    rd_chk(`ADDR_COMM_SETTING, 16'hd8f0);
    done("scaling");
    @(posedge clk);
    fv <= 59'h4a5_f00d_1234_5678;
    repeat (2) @(posedge clk);
    #1;
    chk(dlo, fv[39:0]);
    chk({16'h0, dhi}, {21'h0, fv[58:40]});
    rd_chk(`ADDR_FUNC_DISP_LOW, fv[15:0]);
    rd_chk(`ADDR_FUNC_DISP_HIGH, fv[55:40]);
    done("display");
    rd_chk(`ADDR_PULSE_HZ, 16'h0019);
    rd_chk(`ADDR_PULSE_KHZ, 16'h0002);
    rd_chk(`ADDR_LINE_SPEED, 16'h01f4);
    // Divisor of 7, then zero pulses per meter reads as zero speed
    @(posedge clk);
    ppm <= 16'h0007;
    rd_chk(`ADDR_LINE_SPEED, 16'h00d6);
    @(posedge clk);
    ppm <= 16'h0000;
    rd_chk(`ADDR_LINE_SPEED, 16'h0000);
    // Stopped source: two full gates later the frequency reads zero
    @(posedge clk);
    pon <= 1'b0;
    repeat (250) @(posedge clk);
    rd_chk(`ADDR_PULSE_HZ, 16'h0000);
    done("pulse");
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
